// file: common/rco_defines.vh
// Operation
// - each counter holds up to 32 independent ranges in range mode
// - linear counter: flag error when upper bound is below lower
// - circular counter: upper below lower is accepted without error
// - mask bit 0 and 1 drive digital outputs, bits 2..31 internal outputs
// - in range mode with OR combination, each mask bit set in an active range turns its output on
// - counter pattern is OR of masks of all active ranges
// - range met when lower bound <= counter value <= upper bound
// - on entering a range bound, comparison pauses 1.5 ms for that counter
// - per counter a 32-bit active word plus single flags report met ranges
// - disabled ranges are ignored except in the active word and single flags; all ranges disabled after reset
// - enable mask bit n enables range n of that counter
// - by default unit pattern is OR of both counter patterns
// - config bits 8..15: 0x00 selects OR, 0x01 selects AND in range mode
// - config bits 0..7: 0x00 range mode, 0x01 comparison mode
// - AND combination leaves out a counter with zero ranges configured
// - both counters with zero ranges gives an all-off unit pattern
// - mode is unit-wide; both counters use the same mode
// - a 32-bit status word shows all unit outputs, bit 0 digital out zero
`ifndef RCO_DEFINES_VH
`define RCO_DEFINES_VH
`define RCO_ADDR_W 8
`define RCO_A_CFG 8'h00
`define RCO_A_EN1 8'h01
`define RCO_A_EN2 8'h02
`define RCO_A_CNT1 8'h03
`define RCO_A_CNT2 8'h04
`define RCO_A_ACT1 8'h05
`define RCO_A_ACT2 8'h06
`define RCO_A_OUT 8'h07
`define RCO_A_ERR 8'h08
`define RCO_A_TYPE 8'h09
// range table: 32-word blocks from 0x40 picked by index bits 7..5, range number in bits 4..0
// blocks in order: lower 1, upper 1, mask 1, lower 2, upper 2, mask 2
`define RCO_A_TBL 8'h40
`define RCO_BLK_LO1 3'h2
`define RCO_BLK_UP1 3'h3
`define RCO_BLK_LO2 3'h5
`define RCO_BLK_UP2 3'h6
`define RCO_MAX_CNT 6'h20
`define RCO_CFG_RST 16'h0000
`define RCO_MODE_RANGE 8'h00
`define RCO_COMB_AND 8'h01
`define RCO_NUM_RNG 32
`define RCO_PAUSE_NS 1500000
`define RCO_CLK_NS 40
`endif

// file: rtl/rco_range_ctrl.v
// The register offsets and the plain strobed port were left to the implementer.
`include "rco_defines.vh"
module rco_range_ctrl #(
  parameter PAUSE_CYC = (`RCO_PAUSE_NS + `RCO_CLK_NS - 1) / `RCO_CLK_NS
) (
  input wire clk,
  input wire srst,
  input wire [31:0] count1_val,
  input wire [31:0] count2_val,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg digital_out_zero,
  output reg digital_out_one,
  output reg [29:0] internal_out,
  output reg [31:0] range_active_flag1,
  output reg [31:0] range_active_flag2,
  output reg range_mode,
  output reg limit_err
);
  reg [15:0] output_control_config_r;
  reg [31:0] range_enable_mask_ch1_r;
  reg [31:0] range_enable_mask_ch2_r;
  reg [5:0] range_count1_r;
  reg [5:0] range_count2_r;
  reg [1:0] circ_r;
  reg [31:0] cnt1_s1_r;
  reg [31:0] cnt1_s2_r;
  reg [31:0] cnt2_s1_r;
  reg [31:0] cnt2_s2_r;
  reg [31:0] unit_nxt;
  reg [31:0] unit_r;
  reg rd_tbl_r;
  reg rd_ch2_r;
  reg [31:0] rd_reg_r;
  wire [31:0] act1;
  wire [31:0] act2;
  wire [31:0] pat1;
  wire [31:0] pat2;
  wire [31:0] tbl1;
  wire [31:0] tbl2;
  wire err1;
  wire err2;
  // the 8-bit index holds exactly six 32-word blocks above the plain registers
  function [1:0] fld_of;
    input [2:0] blk;
    begin
      case (blk)
        `RCO_BLK_LO1, `RCO_BLK_LO2: fld_of = 2'h0;
        `RCO_BLK_UP1, `RCO_BLK_UP2: fld_of = 2'h1;
        default: fld_of = 2'h2;
      endcase
    end
  endfunction

  // a count above the table size, upper bits included, is held at the table size
  function [5:0] clamp_cnt;
    input [31:0] v;
    begin
      if (v > {26'h0000000, `RCO_MAX_CNT})
        clamp_cnt = `RCO_MAX_CNT;
      else
        clamp_cnt = v[5:0];
    end
  endfunction

  wire is_tbl = (reg_addr >= `RCO_A_TBL);
  wire tbl_ch2 = (reg_addr[7:5] >= `RCO_BLK_LO2);
  wire [1:0] tbl_fld = fld_of(reg_addr[7:5]);
  wire [4:0] tbl_idx = reg_addr[4:0];
  wire range_sel = (output_control_config_r[7:0] == `RCO_MODE_RANGE);
  wire and_sel = (output_control_config_r[15:8] == `RCO_COMB_AND);

  // counter values arrive from another clock domain
  always @(posedge clk)
  begin
    if (srst)
    begin
      cnt1_s1_r <= 32'h00000000;
      cnt1_s2_r <= 32'h00000000;
      cnt2_s1_r <= 32'h00000000;
      cnt2_s2_r <= 32'h00000000;
    end
    else
    begin
      cnt1_s1_r <= count1_val;
      cnt1_s2_r <= cnt1_s1_r;
      cnt2_s1_r <= count2_val;
      cnt2_s2_r <= cnt2_s1_r;
    end
  end

  rco_range_unit #(
    .NRNG(`RCO_NUM_RNG),
    .PAUSE_CYC(PAUSE_CYC)
  ) u_ch1 (
    .clk(clk),
    .srst(srst),
    .count_val(cnt1_s2_r),
    .circular(circ_r[0]),
    .enable_mask(range_enable_mask_ch1_r),
    .tbl_we(reg_wr && is_tbl && !tbl_ch2),
    .tbl_idx(tbl_idx),
    .tbl_fld(tbl_fld),
    .tbl_wdata(reg_wdata),
    .rd_idx(tbl_idx),
    .rd_fld(tbl_fld),
    .rd_data(tbl1),
    .active_r(act1),
    .pattern_r(pat1),
    .limit_err_r(err1),
    .paused_r()
  );

  rco_range_unit #(
    .NRNG(`RCO_NUM_RNG),
    .PAUSE_CYC(PAUSE_CYC)
  ) u_ch2 (
    .clk(clk),
    .srst(srst),
    .count_val(cnt2_s2_r),
    .circular(circ_r[1]),
    .enable_mask(range_enable_mask_ch2_r),
    .tbl_we(reg_wr && is_tbl && tbl_ch2),
    .tbl_idx(tbl_idx),
    .tbl_fld(tbl_fld),
    .tbl_wdata(reg_wdata),
    .rd_idx(tbl_idx),
    .rd_fld(tbl_fld),
    .rd_data(tbl2),
    .active_r(act2),
    .pattern_r(pat2),
    .limit_err_r(err2),
    .paused_r()
  );

  // combine the two counter patterns into the unit pattern
  always @*
  begin
    unit_nxt = 32'h00000000;
    if (!range_sel)
      unit_nxt = 32'h00000000; // comparison mode not built here; outputs off
    else if ((range_count1_r == 6'h00) && (range_count2_r == 6'h00))
      unit_nxt = 32'h00000000;
    else if (and_sel)
    begin
      if (range_count1_r == 6'h00)
        unit_nxt = pat2;
      else if (range_count2_r == 6'h00)
        unit_nxt = pat1;
      else
        unit_nxt = pat1 & pat2;
    end
    else
      unit_nxt = pat1 | pat2;
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      output_control_config_r <= `RCO_CFG_RST;
      range_enable_mask_ch1_r <= 32'h00000000;
      range_enable_mask_ch2_r <= 32'h00000000;
      range_count1_r <= 6'h00;
      range_count2_r <= 6'h00;
      circ_r <= 2'h0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `RCO_A_CFG: output_control_config_r <= reg_wdata[15:0];
        `RCO_A_EN1: range_enable_mask_ch1_r <= reg_wdata;
        `RCO_A_EN2: range_enable_mask_ch2_r <= reg_wdata;
        `RCO_A_CNT1: range_count1_r <= clamp_cnt(reg_wdata);
        `RCO_A_CNT2: range_count2_r <= clamp_cnt(reg_wdata);
        `RCO_A_TYPE: circ_r <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      unit_r <= 32'h00000000;
      digital_out_zero <= 1'b0;
      digital_out_one <= 1'b0;
      internal_out <= 30'h00000000;
      range_active_flag1 <= 32'h00000000;
      range_active_flag2 <= 32'h00000000;
      range_mode <= 1'b1;
      limit_err <= 1'b0;
    end
    else
    begin
      unit_r <= unit_nxt;
      digital_out_zero <= unit_nxt[0];
      digital_out_one <= unit_nxt[1];
      internal_out <= unit_nxt[31:2];
      range_active_flag1 <= act1;
      range_active_flag2 <= act2;
      range_mode <= range_sel;
      limit_err <= err1 | err2;
    end
  end

  // register read: data stand one cycle after the strobe
  always @(posedge clk)
  begin
    if (srst)
    begin
      rd_tbl_r <= 1'b0;
      rd_ch2_r <= 1'b0;
      rd_reg_r <= 32'h00000000;
    end
    else
    begin
      rd_tbl_r <= reg_rd && is_tbl;
      rd_ch2_r <= tbl_ch2;
      rd_reg_r <= 32'h00000000;
      if (reg_rd)
        case (reg_addr)
          `RCO_A_CFG: rd_reg_r <= {16'h0000, output_control_config_r};
          `RCO_A_EN1: rd_reg_r <= range_enable_mask_ch1_r;
          `RCO_A_EN2: rd_reg_r <= range_enable_mask_ch2_r;
          `RCO_A_CNT1: rd_reg_r <= {26'h0000000, range_count1_r};
          `RCO_A_CNT2: rd_reg_r <= {26'h0000000, range_count2_r};
          `RCO_A_ACT1: rd_reg_r <= act1;
          `RCO_A_ACT2: rd_reg_r <= act2;
          `RCO_A_OUT: rd_reg_r <= unit_r;
          `RCO_A_ERR: rd_reg_r <= {30'h00000000, err2, err1};
          `RCO_A_TYPE: rd_reg_r <= {30'h00000000, circ_r};
          default: rd_reg_r <= 32'h00000000;
        endcase
    end
  end

  always @*
  begin
    if (rd_tbl_r)
      reg_rdata = rd_ch2_r ? tbl2 : tbl1;
    else
      reg_rdata = rd_reg_r;
  end
endmodule // rco_range_ctrl

// file: rtl/rco_range_unit.v
`include "rco_defines.vh"
// one counter: range table, compare, pause timer, active word
module rco_range_unit #(
  parameter NRNG = `RCO_NUM_RNG,
  parameter PAUSE_CYC = (`RCO_PAUSE_NS + `RCO_CLK_NS - 1) / `RCO_CLK_NS
) (
  input wire clk,
  input wire srst,
  input wire [31:0] count_val,
  input wire circular,
  input wire [31:0] enable_mask,
  input wire tbl_we,
  input wire [4:0] tbl_idx,
  input wire [1:0] tbl_fld,
  input wire [31:0] tbl_wdata,
  input wire [4:0] rd_idx,
  input wire [1:0] rd_fld,
  output reg [31:0] rd_data,
  output reg [31:0] active_r,
  output reg [31:0] pattern_r,
  output reg limit_err_r,
  output reg paused_r
);
  reg [31:0] lower_bound [0:NRNG-1];
  reg [31:0] upper_bound [0:NRNG-1];
  reg [31:0] range_output_mask [0:NRNG-1];
  reg [31:0] pause_cnt_r;
  reg [31:0] met;
  reg [31:0] at_bound;
  reg [31:0] pat_nxt;
  reg err_nxt;
  integer i;
  integer j;

  // unsigned compare for circular, signed for linear
  function le;
    input [31:0] a;
    input [31:0] b;
    input circ;
    begin
      if (circ)
        le = (a <= b);
      else
        le = ($signed(a) <= $signed(b));
    end
  endfunction

  always @*
  begin
    met = 32'h00000000;
    at_bound = 32'h00000000;
    pat_nxt = 32'h00000000;
    err_nxt = 1'b0;
    for (i = 0; i < NRNG; i = i + 1)
    begin
      if (circular && (upper_bound[i] < lower_bound[i]))
        met[i] = (count_val >= lower_bound[i]) || (count_val <= upper_bound[i]);
      else
        met[i] = le(lower_bound[i], count_val, circular) && le(count_val, upper_bound[i], circular);
      at_bound[i] = enable_mask[i] && ((count_val == lower_bound[i]) || (count_val == upper_bound[i]));
      if (met[i] && enable_mask[i])
        pat_nxt = pat_nxt | range_output_mask[i];
      if (!circular && enable_mask[i] && le(upper_bound[i], lower_bound[i], 1'b0) &&
          (upper_bound[i] != lower_bound[i]))
        err_nxt = 1'b1;
    end
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      for (j = 0; j < NRNG; j = j + 1)
      begin
        lower_bound[j] <= 32'h00000000;
        upper_bound[j] <= 32'h00000000;
        range_output_mask[j] <= 32'h00000000;
      end
    end
    else if (tbl_we)
    begin
      case (tbl_fld)
        2'h0: lower_bound[tbl_idx] <= tbl_wdata;
        2'h1: upper_bound[tbl_idx] <= tbl_wdata;
        2'h2: range_output_mask[tbl_idx] <= tbl_wdata;
        default: ;
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      active_r <= 32'h00000000;
      pattern_r <= 32'h00000000;
      limit_err_r <= 1'b0;
      paused_r <= 1'b0;
      pause_cnt_r <= 32'h00000000;
    end
    else
    begin
      limit_err_r <= err_nxt;
      if (paused_r)
      begin
        // pattern and active word hold while the counter's comparison is paused; the bound error keeps updating
        if (pause_cnt_r == 32'h00000001)
          paused_r <= 1'b0;
        pause_cnt_r <= pause_cnt_r - 32'h00000001;
      end
      else
      begin
        active_r <= met;
        pattern_r <= pat_nxt;
        if (|at_bound)
        begin
          paused_r <= 1'b1;
          pause_cnt_r <= PAUSE_CYC;
        end
      end
    end
  end

  always @(posedge clk)
  begin
    if (srst)
      rd_data <= 32'h00000000;
    else
      case (rd_fld)
        2'h0: rd_data <= lower_bound[rd_idx];
        2'h1: rd_data <= upper_bound[rd_idx];
        2'h2: rd_data <= range_output_mask[rd_idx];
        default: rd_data <= 32'h00000000;
      endcase
  end
endmodule // rco_range_unit

// file: test/rco_cnt_model.sv
module rco_cnt_model (
  input wire logic [31:0] c1_set,
  input wire logic [31:0] c2_set,
  output wire logic [31:0] count1_val,
  output wire logic [31:0] count2_val
);
  timeunit 1ns;
  timeprecision 1ps;
  // encoders run off their own clocks, so values move away from the block's edges
  assign #13 count1_val = c1_set;
  assign #17 count2_val = c2_set;
endmodule // rco_cnt_model

// file: test/rco_range_ctrl_assertions.sv
module rco_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic [31:0] count1_val,
  input wire logic [31:0] count2_val,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic digital_out_zero,
  input wire logic digital_out_one,
  input wire logic [29:0] internal_out,
  input wire logic [31:0] range_active_flag1,
  input wire logic [31:0] range_active_flag2,
  input wire logic range_mode,
  input wire logic limit_err
);
  logic z1_r, z2_r, circ_r;
  wire [31:0] outs = {internal_out, digital_out_one, digital_out_zero};
  // shadows of range counts and counter types; reset and bus writes move them
  always @(posedge clk)
  begin
    if (srst)
      {z1_r, z2_r, circ_r} <= 3'h6;
    else if (reg_wr)
    begin
      case (reg_addr)
        8'h03: z1_r <= reg_wdata == 32'h0;
        8'h04: z2_r <= reg_wdata == 32'h0;
        8'h09: circ_r <= reg_wdata[1:0] == 2'h3;
        default: ;
      endcase
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_mode_range: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[7:0] == 8'h00 |-> ##[1:2] range_mode)
    else $error("range mode missing");
  a_mode_cmp: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[7:0] == 8'h01 |-> ##[1:2] !range_mode)
    else $error("comparison mode missing");
  a_cmp_off: assert property (!range_mode [*4] |-> outs == 32'h0)
    else $error("outputs on outside range mode");
  a_zero_off: assert property ((z1_r && z2_r) [*6] |-> outs == 32'h0)
    else $error("outputs on with no ranges");
  a_circ_ok: assert property (circ_r [*4] |-> !limit_err)
    else $error("bound error on circular counters");
  a_status_rd: assert property (reg_rd && reg_addr == 8'h07 ##1 $stable(outs) |-> reg_rdata == outs)
    else $error("status word differs from outputs");
  a_err_rd: assert property (reg_rd && reg_addr == 8'h08 ##1 $stable(limit_err) |-> (|reg_rdata[1:0]) == limit_err)
    else $error("error word differs from error flag");
  a_act_rd: assert property (reg_rd && reg_addr == 8'h05 ##1 $stable(range_active_flag1)
    |-> reg_rdata == range_active_flag1)
    else $error("active word differs from flags");
endmodule // rco_chk

// file: test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, c1_set, c2_set, rdv, cfg, ty;
  logic [31:0] lo[2][2], hi[2][2], mk[2][2], en[2], n[2];
  wire [31:0] count1_val, count2_val, reg_rdata, range_active_flag1, range_active_flag2;
  wire [29:0] internal_out;
  wire digital_out_zero, digital_out_one, range_mode, limit_err;
  wire [31:0] outs = {internal_out, digital_out_one, digital_out_zero};
  integer bad_count = 0, total_checks = 0, cyc = 0, seed = 90834, i;

  rco_cnt_model u_rco_cnt_model (
    .c1_set(c1_set),
    .c2_set(c2_set),
    .count1_val(count1_val),
    .count2_val(count2_val)
  );
  rco_range_ctrl #(.PAUSE_CYC(20)) u_rco_range_ctrl (
    .clk(clk),
    .srst(srst),
    .count1_val(count1_val),
    .count2_val(count2_val),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .digital_out_zero(digital_out_zero),
    .digital_out_one(digital_out_one),
    .internal_out(internal_out),
    .range_active_flag1(range_active_flag1),
    .range_active_flag2(range_active_flag2),
    .range_mode(range_mode),
    .limit_err(limit_err)
  );

  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count = bad_count + 1;
      wrap_up();
    end
  end

  function automatic logic inr(logic [31:0] l, logic [31:0] h, logic [31:0] v, logic circ);
    return circ ? (l <= h ? v >= l && v <= h : v >= l || v <= h) : $signed(l) <= $signed(v) && $signed(v) <= $signed(h);
  endfunction

  function automatic logic [31:0] act(int ch);
    logic [31:0] a = 0;
    for (int r = 0; r < 2; r++)
      a[r] = inr(lo[ch][r], hi[ch][r], ch ? c2_set : c1_set, ty[ch]);
    return a & en[ch];
  endfunction

  function automatic logic [31:0] cpat(int ch);
    logic [31:0] a = act(ch);
    logic [31:0] p = 0;
    for (int r = 0; r < 2; r++)
      if (a[r])
        p = p | mk[ch][r];
    return p;
  endfunction

  function automatic logic [31:0] unit_pat();
    if (cfg[7:0] != 8'h00 || (n[0] == 0 && n[1] == 0))
      return 32'h0;
    if (cfg[15:8] == 8'h01)
      return n[0] == 0 ? cpat(1) : n[1] == 0 ? cpat(0) : cpat(0) & cpat(1);
    return cpat(0) | cpat(1);
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
  endtask

  task automatic rd(logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 rdv = reg_rdata;
  endtask

  task automatic setr(int ch, int r, logic [31:0] l, logic [31:0] h, logic [31:0] m);
    logic [7:0] a = 8'h40 + 8'(ch * 96 + r);
    lo[ch][r] = l;
    hi[ch][r] = h;
    mk[ch][r] = m;
    wr(a, l);
    wr(a + 8'h20, h);
    wr(a + 8'h40, m);
  endtask

  task automatic check_all();
    repeat (40) @(posedge clk);
    rd(8'h07);
    chk("outs", unit_pat(), outs);
    chk("status", unit_pat(), rdv);
    chk("flag1", act(0), range_active_flag1 & en[0]);
    chk("flag2", act(1), range_active_flag2 & en[1]);
    rd(8'h05);
    chk("act1", act(0), rdv & en[0]);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    {srst, reg_wr, reg_rd, reg_addr, reg_wdata, c1_set, c2_set, cfg, ty} = {1'b1, 170'h0};
    en = '{0, 0};
    n = '{0, 0};
    repeat (2) @(posedge clk);
    srst <= 0;
    rd(8'h00);
    chk("cfg", 32'h0, rdv);
    rd(8'h01);
    chk("en1", 32'h0, rdv);
    chk("mode", 32'h1, 32'(range_mode));
    rd(8'h20);
    chk("unmapped", 32'h0, rdv);
    setr(0, 0, -5, 20, 32'h5);
    setr(0, 1, 15, 30, 32'h8);
    setr(1, 0, 0, 100, 32'hFFFF0003);
    rd(8'h40);
    chk("lower1", 32'hFFFFFFFB, rdv);
    rd(8'h61);
    chk("upper1", 32'd30, rdv);
    rd(8'hE0);
    chk("mask2", 32'hFFFF0003, rdv);
    n = '{2, 1};
    en = '{3, 1};
    wr(8'h03, 2);
    wr(8'h04, 1);
    wr(8'h01, 3);
    wr(8'h02, 1);
    c2_set = 50;
    for (i = 0; i < 10; i++)
    begin
      c1_set = i == 0 ? -5 : i == 1 ? 31 : $random(seed) % 40;
      check_all();
    end
    c1_set = 25;
    check_all();
    c1_set = 20;
    c2_set = 200;
    repeat (6) @(posedge clk);
    c1_set = 100;
    repeat (8) @(posedge clk);
    #1;
    chk("paused", 32'h1, 32'(range_active_flag1 != 0));
    chk("other", 32'h0, range_active_flag2 & en[1]);
    check_all();
    c2_set = 50;
    c1_set = 0;
    en[0] = 1;
    wr(8'h01, 1);
    check_all();
    cfg = 32'h0100;
    wr(8'h00, cfg);
    check_all();
    n[1] = 0;
    wr(8'h04, 0);
    check_all();
    n[0] = 0;
    wr(8'h03, 0);
    check_all();
    n = '{2, 1};
    wr(8'h03, 2);
    wr(8'h04, 1);
    cfg = 32'h1;
    wr(8'h00, cfg);
    check_all();
    chk("mode", 32'h0, 32'(range_mode));
    cfg = 32'h0;
    wr(8'h00, cfg);
    setr(1, 1, 9, 3, 32'h4);
    n[1] = 2;
    en[1] = 3;
    wr(8'h04, 2);
    wr(8'h02, 3);
    c2_set = 2;
    check_all();
    rd(8'h08);
    chk("errs", 32'h2, rdv);
    chk("err", 32'h1, 32'(limit_err));
    ty = 32'h3;
    wr(8'h09, ty);
    check_all();
    chk("err", 32'h0, 32'(limit_err));
    wrap_up();
  end
endmodule // tb

bind rco_range_ctrl rco_chk u_chk (
  .clk(clk),
  .srst(srst),
  .count1_val(count1_val),
  .count2_val(count2_val),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .digital_out_zero(digital_out_zero),
  .digital_out_one(digital_out_one),
  .internal_out(internal_out),
  .range_active_flag1(range_active_flag1),
  .range_active_flag2(range_active_flag2),
  .range_mode(range_mode),
  .limit_err(limit_err)
);
